// *** pbs_control.sv ***
// Top of the pipelined burst memory: strobes, burst engine, array,
// pass-through and pin drive, plus a small AHB-Lite register slave.
// Assumes all pins are synchronous to clk; data pins are split in/out/enable.
//
// Added by the designer: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module pbs_control
  import pbs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AHB-Lite register slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Memory address and selects
  input wire logic [pbs_pkg::ADDR_W-1:0] addrIn,
  input wire logic chipSelectPrimary,
  input wire logic chipSelectPos,
  input wire logic chipSelectNeg,
  // Burst strobes
  input wire logic procAddrStrobeN,
  input wire logic ctrlAddrStrobeN,
  input wire logic burstAdvanceN,
  input wire logic burstOrderSelect,
  // Write controls
  input wire logic globalWriteN,
  input wire logic byteWriteGateN,
  input wire logic [pbs_pkg::LANES-1:0] laneWriteN,
  // Asynchronous-class controls, sampled here
  input wire logic outputEnableN,
  input wire logic sleepRequest,
  // Data pins
  input wire logic [pbs_pkg::DATA_W-1:0] dqIn,
  output logic [pbs_pkg::DATA_W-1:0] dqOut,
  output logic [pbs_pkg::DATA_W-1:0] dqOe
);
  pbs_state_t state_q, state_d;
  logic [1:0] wakeCnt_q;
  logic [ADDR_W-3:0] upper_q;
  logic [ADDR_W-1:0] rdAddr_q;
  logic readPend_q;
  logic wrPend_q;
  logic [LANES-1:0] wrLanes_q;
  logic [DATA_W-1:0] wrData_q;
  logic writeProtect_q;
  logic phaseValid_q;
  logic phaseWrite_q;
  logic [7:0] phaseAddr_q;
  logic [DATA_W-1:0] dqOut_d;
  logic [DATA_W-1:0] dqOe_d;
  logic [DATA_W-1:0] laneRd;
  logic [1:0] curLow;
  logic [1:0] nextLow;
  logic writeDec;
  logic [LANES-1:0] laneWe;
  logic csSel, procStart, strobe, awake, burstActive;
  logic startEv, deselEv, contEv, startWr, opWrite, opRead, pinsOn;
  logic [ADDR_W-1:0] accessAddr;

  // Write decode of the sampled controls
  pbs_write_decode u_wdec (
    .globalWriteN(globalWriteN),
    .byteWriteGateN(byteWriteGateN),
    .laneWriteN(laneWriteN),
    .writeDec(writeDec),
    .laneWe(laneWe)
  );

  // Burst counter over the two low address bits
  pbs_burst_counter u_bcnt (
    .clk(clk),
    .rst(rst),
    .load(startEv),
    .advance(contEv && !burstAdvanceN),
    .startLow(addrIn[1:0]),
    .orderInterleaved(burstOrderSelect),
    .curLow(curLow),
    .nextLow(nextLow)
  );

  // Strobe and select decode; primary select high blocks the processor strobe
  always_comb
  begin
    csSel = !chipSelectPrimary && chipSelectPos && !chipSelectNeg;
    procStart = !procAddrStrobeN && !chipSelectPrimary;
    strobe = procStart || !ctrlAddrStrobeN;
    // Sleep input has no pull model here; a driven low is normal operation
    awake = !sleepRequest && (state_q != ST_SLEEP) && (state_q != ST_WAKE);
    burstActive = (state_q == ST_READ) || (state_q == ST_WRITE);
    startEv = awake && strobe && csSel;
    deselEv = awake && strobe && !csSel;
    contEv = awake && !strobe && burstActive;
    startWr = !procStart && writeDec;
  end

  // Access direction and address of this edge
  always_comb
  begin
    if (startEv)
    begin
      // Processor start ignores advance and lane writes
      opWrite = startWr;
      opRead = !startWr;
      accessAddr = addrIn;
    end
    else if (contEv)
    begin
      opWrite = writeDec;
      opRead = !writeDec;
      if (!burstAdvanceN)
      begin
        accessAddr = {upper_q, nextLow};
      end
      else
      begin
        accessAddr = {upper_q, curLow};
      end
    end
    else
    begin
      opWrite = 1'b0;
      opRead = 1'b0;
      accessAddr = rdAddr_q;
    end
  end

  // Burst state, with two wake cycles after sleep
  always_comb
  begin
    state_d = state_q;
    if (sleepRequest)
    begin
      state_d = ST_SLEEP;
    end
    else if (state_q == ST_SLEEP)
    begin
      state_d = ST_WAKE;
    end
    else if (state_q == ST_WAKE)
    begin
      if (wakeCnt_q == WAKE_CYCLES - 2'h1)
      begin
        state_d = ST_IDLE;
      end
    end
    else if (deselEv)
    begin
      state_d = ST_IDLE;
    end
    else if (startEv || contEv)
    begin
      state_d = opWrite ? ST_WRITE : ST_READ;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      wakeCnt_q <= 2'h0;
    end
    else
    begin
      state_q <= state_d;
      wakeCnt_q <= (state_q == ST_WAKE) ? 2'(wakeCnt_q + 2'h1) : 2'h0;
    end
  end

  // Upper address bits load only on a start and hold through the burst
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      upper_q <= '0;
    end
    else if (startEv)
    begin
      upper_q <= addrIn[ADDR_W-1:2];
    end
  end

  // Pipeline flags; write data and lanes are taken on the edge only
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdAddr_q <= '0;
      readPend_q <= 1'b0;
      wrPend_q <= 1'b0;
      wrLanes_q <= '0;
      wrData_q <= '0;
    end
    else
    begin
      rdAddr_q <= accessAddr;
      readPend_q <= opRead;
      wrPend_q <= opWrite;
      wrLanes_q <= laneWe & {LANES{opWrite}};
      wrData_q <= dqIn;
    end
  end

  // Byte-lane storage; contents are not reset and survive sleep
  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      logic [LANE_W-1:0] laneMem [0:DEPTH-1];

      // Array write at the access address; write protect blocks it
      always_ff @(posedge clk)
      begin
        if (opWrite && laneWe[g] && !writeProtect_q)
        begin
          laneMem[accessAddr] <= dqIn[g*LANE_W +: LANE_W];
        end
      end

      assign laneRd[g*LANE_W +: LANE_W] = laneMem[rdAddr_q];

      // Lane data: pending read, else last cycle's write passes through
      always_comb
      begin
        if (readPend_q)
        begin
          dqOut_d[g*LANE_W +: LANE_W] = laneRd[g*LANE_W +: LANE_W];
          dqOe_d[g*LANE_W +: LANE_W] = {LANE_W{pinsOn}};
        end
        else if (wrPend_q)
        begin
          dqOut_d[g*LANE_W +: LANE_W] = wrData_q[g*LANE_W +: LANE_W];
          dqOe_d[g*LANE_W +: LANE_W] = {LANE_W{pinsOn && wrLanes_q[g]}};
        end
        else
        begin
          dqOut_d[g*LANE_W +: LANE_W] = dqOut[g*LANE_W +: LANE_W];
          dqOe_d[g*LANE_W +: LANE_W] = '0;
        end
      end
    end
  endgenerate

  // Drive allowed only with sleep request low, enable low and no write sampled now
  assign pinsOn = !sleepRequest && !outputEnableN && !opWrite;

  // Pin registers; pass-through needs no extra stage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dqOut <= '0;
      dqOe <= '0;
    end
    else
    begin
      dqOut <= dqOut_d;
      dqOe <= dqOe_d;
    end
  end

  // AHB address phase capture; zero wait states, always OKAY
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      phaseValid_q <= 1'b0;
      phaseWrite_q <= 1'b0;
      phaseAddr_q <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      phaseValid_q <= hready && hsel && htrans[HTRANS_ACTIVE_BIT];
      phaseWrite_q <= hwrite;
      phaseAddr_q <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Control register written in the data phase; unmapped writes dropped
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      writeProtect_q <= CTRL_WPROT_RST;
    end
    else if (phaseValid_q && phaseWrite_q && (phaseAddr_q == REG_CTRL))
    begin
      writeProtect_q <= hwdata[CTRL_WPROT_BIT];
    end
  end

  // Read data registered at the address phase, valid for the data phase
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hrdata <= '0;
    end
    else if (hready && hsel && htrans[HTRANS_ACTIVE_BIT] && !hwrite)
    begin
      hrdata <= '0;
      case (haddr[7:0])
        REG_CTRL: hrdata[CTRL_WPROT_BIT] <= writeProtect_q;
        REG_STATUS:
        begin
          hrdata[STAT_SLEEP_BIT] <= !awake;
          hrdata[STAT_BURST_BIT] <= burstActive;
          hrdata[STAT_WRITE_BIT] <= state_q == ST_WRITE;
          hrdata[STAT_WPROT_BIT] <= writeProtect_q;
          hrdata[STAT_ADDR_LSB +: ADDR_W] <= rdAddr_q;
        end
        default: hrdata <= '0;
      endcase
    end
  end

  // Checks on the access engine and the pins
  property p_sleep_float;
    @(posedge clk) disable iff (rst) sleepRequest |=> dqOe == '0;
  endproperty
  a_sleep_float: assert property (p_sleep_float) else $error("pins driven while asleep");

  property p_oe_float;
    @(posedge clk) disable iff (rst) outputEnableN |=> dqOe == '0;
  endproperty
  a_oe_float: assert property (p_oe_float) else $error("pins driven with output enable high");

  property p_proc_read;
    @(posedge clk) disable iff (rst)
      (awake && procStart && csSel) |=> readPend_q && rdAddr_q == $past(addrIn) && state_q == ST_READ;
  endproperty
  a_proc_read: assert property (p_proc_read) else $error("processor strobe did not start a read");

  property p_ctrl_write;
    @(posedge clk) disable iff (rst)
      (awake && !procStart && !ctrlAddrStrobeN && csSel && !globalWriteN) |=> state_q == ST_WRITE && !readPend_q;
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("controller strobe did not start a write");

  property p_desel;
    @(posedge clk) disable iff (rst) deselEv |=> state_q == ST_IDLE && !readPend_q && !wrPend_q;
  endproperty
  a_desel: assert property (p_desel) else $error("deselected edge made an access");

  property p_advance;
    @(posedge clk) disable iff (rst)
      (contEv && !burstAdvanceN) |=> rdAddr_q[1:0] != $past(rdAddr_q[1:0]) && rdAddr_q[ADDR_W-1:2] == $past(upper_q);
  endproperty
  a_advance: assert property (p_advance) else $error("burst did not advance");

  property p_suspend;
    @(posedge clk) disable iff (rst) (contEv && burstAdvanceN) |=> rdAddr_q == $past(rdAddr_q);
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspended burst moved");

  property p_read_pipe;
    @(posedge clk) disable iff (rst)
      opRead ##1 (!outputEnableN && !sleepRequest && !opWrite) |=> dqOe == '1 && dqOut == $past(laneRd);
  endproperty
  a_read_pipe: assert property (p_read_pipe) else $error("read data not driven one edge later");

  property p_pass_full;
    @(posedge clk) disable iff (rst)
      (opWrite && laneWe == 4'hF) ##1 (!outputEnableN && !sleepRequest && !opWrite)
        |=> dqOe == '1 && dqOut == $past(dqIn, 2);
  endproperty
  a_pass_full: assert property (p_pass_full) else $error("full write not passed through");

  property p_pass_lane;
    @(posedge clk) disable iff (rst)
      (opWrite && laneWe == 4'h1) ##1 (!outputEnableN && !sleepRequest && !opWrite)
        |=> dqOe == 32'h0000_00FF ##1 ($past(readPend_q) || dqOe == '0);
  endproperty
  a_pass_lane: assert property (p_pass_lane) else $error("single lane pass-through wrong");

  property p_wake;
    @(posedge clk) disable iff (rst)
      (state_q == ST_SLEEP && !sleepRequest) |=> !awake ##1 !awake
        ##1 (state_q == ST_IDLE || sleepRequest || $past(sleepRequest) || $past(sleepRequest, 2));
  endproperty
  a_wake: assert property (p_wake) else $error("wake-up time not two cycles");

  property p_wdecode;
    @(posedge clk) disable iff (rst)
      (globalWriteN && (byteWriteGateN || laneWriteN == 4'hF)) |-> !writeDec && laneWe == 4'h0;
  endproperty
  a_wdecode: assert property (p_wdecode) else $error("read decoded as write");

  // Main scenarios
  c_proc_read: cover property (@(posedge clk) disable iff (rst) opRead ##1 contEv ##1 contEv);
  c_pass_read: cover property (@(posedge clk) disable iff (rst) opWrite ##1 (startEv && opRead) ##1 readPend_q);
  c_wake: cover property (@(posedge clk) disable iff (rst) state_q == ST_WAKE ##2 startEv);
endmodule // pbs_control

// *** pbs_pkg.sv ***
// Constants shared by the pipelined burst memory control block.
// Assumes one 125 MHz clock and a single AHB-Lite master on the register port.
package pbs_pkg;
  // Array geometry
  localparam int ADDR_W = 15;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int DEPTH = 32768;

  // Clock rate and wake-up time after sleep, in clock cycles
  localparam int CLK_PERIOD_NS = 8;
  localparam logic [1:0] WAKE_CYCLES = 2'h2;

  // Register byte offsets on the AHB-Lite port
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;

  // Control register fields and reset values
  localparam int CTRL_WPROT_BIT = 0;
  localparam logic CTRL_WPROT_RST = 1'b0;

  // Status register fields
  localparam int STAT_SLEEP_BIT = 0;
  localparam int STAT_BURST_BIT = 1;
  localparam int STAT_WRITE_BIT = 2;
  localparam int STAT_WPROT_BIT = 3;
  localparam int STAT_ADDR_LSB = 4;

  // AHB transfer type bit that marks NONSEQ or SEQ
  localparam int HTRANS_ACTIVE_BIT = 1;

  // Burst state of the access engine
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_READ  = 3'b001,
    ST_WRITE = 3'b010,
    ST_SLEEP = 3'b011,
    ST_WAKE  = 3'b100
  } pbs_state_t;
endpackage

// *** pbs_burst_counter.sv ***
// Two-bit burst address counter with linear or interleaved order.
// Assumes the order select is a steady strap from the far side.
`timescale 1ns/1ps
module pbs_burst_counter
  import pbs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic load,
  input wire logic advance,
  input wire logic [1:0] startLow,
  input wire logic orderInterleaved,
  // Low address bits now and after one advance
  output logic [1:0] curLow,
  output logic [1:0] nextLow
);
  logic [1:0] start_q;
  logic [1:0] count_q;
  logic [1:0] countNext;

  // Start value and step count; count wraps from 3 back to 0
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      start_q <= 2'h0;
      count_q <= 2'h0;
    end
    else if (load)
    begin
      start_q <= startLow;
      count_q <= 2'h0;
    end
    else if (advance)
    begin
      count_q <= countNext;
    end
  end

  // Order mapping; only the two low bits ever move
  always_comb
  begin
    countNext = 2'(count_q + 2'h1);
    if (orderInterleaved)
    begin
      curLow = start_q ^ count_q;
      nextLow = start_q ^ countNext;
    end
    else
    begin
      curLow = 2'(start_q + count_q);
      nextLow = 2'(start_q + countNext);
    end
  end

  // Interleaved step goes through start XOR count
  property p_interleave_step;
    @(posedge clk) disable iff (rst)
      (load && orderInterleaved) ##1 (advance && !load && orderInterleaved) |=> curLow == ($past(curLow) ^ 2'h1);
  endproperty
  a_interleave_step: assert property (p_interleave_step) else $error("interleaved burst step wrong");
endmodule // pbs_burst_counter

// *** pbs_write_decode.sv ***
// Decodes global write, byte gate and lane writes into a lane mask.
// Assumes all inputs are sampled on the rising edge by the caller.
`timescale 1ns/1ps
module pbs_write_decode
  import pbs_pkg::*;
(
  // Sampled write controls, all active low
  input wire logic globalWriteN,
  input wire logic byteWriteGateN,
  input wire logic [LANES-1:0] laneWriteN,
  // Decoded write
  output logic writeDec,
  output logic [LANES-1:0] laneWe
);
  // Global write takes all lanes; gated lane writes take only their own
  always_comb
  begin
    if (!globalWriteN)
    begin
      laneWe = '1;
    end
    else if (!byteWriteGateN)
    begin
      laneWe = ~laneWriteN;
    end
    else
    begin
      laneWe = '0;
    end
    writeDec = |laneWe;
  end
endmodule // pbs_write_decode

// *** pbs_host_pkg.sv ***
// Operation codes shared by the host pin model and the bench.
// Assumes one code is applied per clock cycle.
package pbs_host_pkg;
  localparam logic [3:0] OP_HLD = 4'h0;
  localparam logic [3:0] OP_PRD = 4'h1;
  localparam logic [3:0] OP_CRD = 4'h2;
  localparam logic [3:0] OP_CWR = 4'h3;
  localparam logic [3:0] OP_ADV = 4'h4;
  localparam logic [3:0] OP_AWR = 4'h5;
  localparam logic [3:0] OP_DES = 4'h6;
  localparam logic [3:0] OP_SLP = 4'h7;
  localparam logic [3:0] OP_ROH = 4'h8;
  localparam logic [3:0] OP_PRB = 4'h9;
endpackage

// *** pbs_host_model.sv ***
// Host pin model: address, selects, strobes, write controls, enable, sleep.
// Assumes drive is called once per cycle; the bench straps the order select.
`timescale 1ns/1ps
module pbs_host_model
  import pbs_pkg::*;
  import pbs_host_pkg::*;
(
  // Clock
  input wire logic clk,
  // Device data outputs
  input wire logic [pbs_pkg::DATA_W-1:0] dqOut,
  input wire logic [pbs_pkg::DATA_W-1:0] dqOe,
  // Pins towards the device
  output logic [pbs_pkg::ADDR_W-1:0] addrIn,
  output logic chipSelectPrimary,
  output logic chipSelectPos,
  output logic chipSelectNeg,
  output logic procAddrStrobeN,
  output logic ctrlAddrStrobeN,
  output logic burstAdvanceN,
  output logic globalWriteN,
  output logic byteWriteGateN,
  output logic [pbs_pkg::LANES-1:0] laneWriteN,
  output logic outputEnableN,
  output logic sleepRequest,
  output logic [pbs_pkg::DATA_W-1:0] dqIn
);
  logic busEn = 1'b0;
  logic [DATA_W-1:0] busQ = '0;
  logic [DATA_W-1:0] lastQ = '0;

  // Wire level; an undriven pin flips every cycle so no stale value survives
  assign dqIn = (dqOe & dqOut) | (~dqOe & (busEn ? busQ : ~lastQ));
  always @(posedge clk) lastQ <= dqIn;

  // Quiet pins at time zero, sleep held low
  initial
  begin
    {chipSelectPrimary, chipSelectPos, chipSelectNeg} = 3'h2;
    {procAddrStrobeN, ctrlAddrStrobeN, burstAdvanceN, globalWriteN, byteWriteGateN} = 5'h1F;
    {laneWriteN, outputEnableN, sleepRequest} = 6'h3E;
    addrIn = '0;
  end

  // One cycle of pins, changed right after the edge and held a full cycle
  task automatic drive(input logic [3:0] k, input logic [ADDR_W-1:0] a, input logic [LANES-1:0] we,
    input logic [DATA_W-1:0] d);
    logic p1, p2, n2, ps, cs, burst_advance_n, gw, bg, oe, zz, en;
    logic [LANES-1:0] ln;
    // Defaults: selected, no strobe, no advance, read, enable low, awake
    {p1, p2, n2, ps, cs, burst_advance_n, gw, bg, oe, zz, en} = 11'h2F8;
    ln = 4'hF;
    case (k)
      OP_PRD: {ps, burst_advance_n, bg, ln} = 7'h00;
      OP_CRD: {cs, bg} = 2'h0;
      OP_CWR: {cs, oe, en, gw, bg, ln} = {3'h3, (we == 4'hF) ? 6'h1F : {2'h2, ~we}};
      OP_ADV: burst_advance_n = 1'b0;
      OP_AWR: {burst_advance_n, oe, en, gw} = 4'h6;
      OP_DES: {p1, cs, p2, ps, n2} = (we[1:0] == 2'h0) ? 5'h16 : (we[1:0] == 2'h1) ? 5'h08 : 5'h0D;
      OP_SLP: zz = 1'b1;
      OP_ROH: oe = 1'b1;
      OP_PRB: {p1, ps, burst_advance_n} = 3'h4;
      default: ;
    endcase
    @(posedge clk);
    addrIn <= a;
    chipSelectPrimary <= p1;
    chipSelectPos <= p2;
    chipSelectNeg <= n2;
    procAddrStrobeN <= ps;
    ctrlAddrStrobeN <= cs;
    burstAdvanceN <= burst_advance_n;
    globalWriteN <= gw;
    byteWriteGateN <= bg;
    laneWriteN <= ln;
    outputEnableN <= oe;
    sleepRequest <= zz;
    busEn <= en;
    busQ <= d;
  endtask
endmodule // pbs_host_model

// *** testbench.sv ***
// Bench: pin sequences through the host model, registers over AHB-Lite.
// Assumes two-edge pin latency and a zero-wait register slave.
`timescale 1ns/1ps
module testbench
  import pbs_pkg::*;
  import pbs_host_pkg::*;
;
  localparam logic [31:0] FULL = 32'hFFFF_FFFF;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic burstOrderSelect = 1'b0;
  logic [ADDR_W-1:0] addrIn;
  logic chipSelectPrimary, chipSelectPos, chipSelectNeg, procAddrStrobeN, ctrlAddrStrobeN, burstAdvanceN;
  logic globalWriteN, byteWriteGateN, outputEnableN, sleepRequest;
  logic [LANES-1:0] laneWriteN;
  logic [DATA_W-1:0] dqIn, dqOut, dqOe;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  logic [63:0] expQ [$];
  logic [31:0] r, word;
  logic [3:0] masks [3] = '{4'h1, 4'h2, 4'hC};

  always #4 clk = ~clk;

  pbs_control i_pbs_control (.clk(clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .addrIn(addrIn), .chipSelectPrimary(chipSelectPrimary),
    .chipSelectPos(chipSelectPos), .chipSelectNeg(chipSelectNeg), .procAddrStrobeN(procAddrStrobeN),
    .ctrlAddrStrobeN(ctrlAddrStrobeN), .burstAdvanceN(burstAdvanceN), .burstOrderSelect(burstOrderSelect),
    .globalWriteN(globalWriteN), .byteWriteGateN(byteWriteGateN), .laneWriteN(laneWriteN),
    .outputEnableN(outputEnableN), .sleepRequest(sleepRequest), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe));

  pbs_host_model i_pbs_host_model (.clk(clk), .dqOut(dqOut), .dqOe(dqOe), .addrIn(addrIn),
    .chipSelectPrimary(chipSelectPrimary), .chipSelectPos(chipSelectPos), .chipSelectNeg(chipSelectNeg),
    .procAddrStrobeN(procAddrStrobeN), .ctrlAddrStrobeN(ctrlAddrStrobeN), .burstAdvanceN(burstAdvanceN),
    .globalWriteN(globalWriteN), .byteWriteGateN(byteWriteGateN), .laneWriteN(laneWriteN),
    .outputEnableN(outputEnableN), .sleepRequest(sleepRequest), .dqIn(dqIn));

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Hang guard, well above the roughly 75 cycles the run needs
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      mismatches++;
      summarize();
    end
  end

  function automatic logic [31:0] laneMask(input logic [3:0] m);
    return {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
  endfunction

  function automatic logic [31:0] pat(input logic [1:0] l);
    return {8'h5A, 6'h00, l, 8'hC3, 6'h00, l};
  endfunction

  // One pin cycle; its outputs land two edges later, so compare with a lag
  task automatic step(input logic [3:0] k, input logic [ADDR_W-1:0] a, input logic [3:0] we,
    input logic [31:0] d, input logic [31:0] eOut, input logic [31:0] eOe);
    logic [63:0] e;
    i_pbs_host_model.drive(k, a, we, d);
    #1;
    expQ.push_back({eOut, eOe});
    if (expQ.size() > 2)
    begin
      e = expQ.pop_front();
      check(dqOe, e[31:0]);
      check(dqOut & e[31:0], e[63:32] & e[31:0]);
    end
  endtask

  // Settle the pins deselected before the pipeline loses step
  task automatic flush();
    step(OP_DES, 15'h0000, 4'h0, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    step(OP_DES, 15'h0000, 4'h0, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    expQ.delete();
  endtask

  // Single AHB-Lite word transfer; waits on hready at both phases
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(dqOe, 32'h0000_0000);
    check({31'h0, hresp}, 32'h0000_0000);
    ahb(1'b0, REG_CTRL, 32'h0000_0000, r);
    check(r, 32'h0000_0000);
    // Linear write burst from low 01, wrapping to 00, then reads
    step(OP_CWR, 15'h0101, 4'hF, pat(1), 32'h0000_0000, 32'h0000_0000);
    for (int i = 1; i < 4; i++) step(OP_AWR, 15'h7EFE, 4'hF, pat(2'(i + 1)), pat(0), (i == 3) ? FULL : 0);
    step(OP_PRD, 15'h0102, 4'h0, 32'h0000_0000, pat(2), FULL);
    step(OP_ADV, 15'h7FFF, 4'h0, 32'h0000_0000, pat(3), FULL);
    // Enable is sampled with the output edge, so the high level floats the hold before it
    step(OP_HLD, 15'h7FFF, 4'h0, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    step(OP_ROH, 15'h7FFF, 4'h0, 32'h0000_0000, pat(3), FULL);
    step(OP_ADV, 15'h7FFF, 4'h0, 32'h0000_0000, pat(0), FULL);
    step(OP_CRD, 15'h0102, 4'h0, 32'h0000_0000, pat(2), FULL);
    step(OP_PRB, 15'h0100, 4'h0, 32'h0000_0000, pat(3), FULL);
    for (int i = 0; i < 3; i++) step(OP_DES, 15'h0101, 4'(i), 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    step(OP_HLD, 15'h0101, 4'h0, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    // Interleaved order from low 01
    burstOrderSelect <= 1'b1;
    step(OP_PRD, 15'h0101, 4'h0, 32'h0000_0000, pat(1), FULL);
    for (int i = 1; i < 4; i++) step(OP_ADV, 15'h0000, 4'h0, 32'h0000_0000, pat(2'(i) ^ 2'h1), FULL);
    // Enable lags a cycle, so the last read drains before any write data goes on
    flush();
    // Lane writes with pass-through on the written lanes only
    word = 32'h0F0F_0F0F;
    step(OP_CWR, 15'h0200, 4'hF, word, word, FULL);
    step(OP_DES, 15'h0000, 4'h0, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    step(OP_DES, 15'h0000, 4'h0, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    foreach (masks[i])
    begin
      step(OP_CWR, 15'h0200, masks[i], word ^ {8{4'(i + 1)}}, word ^ {8{4'(i + 1)}}, laneMask(masks[i]));
      step(OP_DES, 15'h0000, 4'h0, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
      // Pass-through drive must drop before the next write samples the pins
      step(OP_DES, 15'h0000, 4'h0, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
      word = (word & ~laneMask(masks[i])) | ((word ^ {8{4'(i + 1)}}) & laneMask(masks[i]));
    end
    step(OP_CWR, 15'h0200, 4'h8, 32'h7700_0000, 32'h0000_0000, 32'h0000_0000);
    word = {8'h77, word[23:0]};
    // No strobe keeps the write burst alive, so this repeats a read at the burst address
    step(OP_ROH, 15'h0000, 4'h0, 32'h0000_0000, word, FULL);
    step(OP_PRD, 15'h0200, 4'h0, 32'h0000_0000, word, FULL);
    flush();
    // Write protect blocks the array but not the pass-through
    ahb(1'b1, REG_CTRL, 32'h0000_0001, r);
    ahb(1'b0, REG_STATUS, 32'h0000_0000, r);
    check({31'h0, r[STAT_WPROT_BIT]}, 32'h0000_0001);
    step(OP_CWR, 15'h0200, 4'hF, 32'h9999_9999, 32'h9999_9999, FULL);
    flush();
    ahb(1'b1, 8'h40, 32'hFFFF_FFFF, r);
    ahb(1'b0, 8'h40, 32'h0000_0000, r);
    check(r, 32'h0000_0000);
    ahb(1'b1, REG_CTRL, 32'h0000_0000, r);
    step(OP_PRD, 15'h0200, 4'h0, 32'h0000_0000, word, FULL);
    // Lets the protected word show before sleep floats the pins
    step(OP_DES, 15'h0000, 4'h0, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    // Sleep with enable low, strobes ignored while waking, contents kept
    step(OP_SLP, 15'h0102, 4'h0, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    step(OP_PRD, 15'h0102, 4'h0, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    step(OP_PRD, 15'h0102, 4'h0, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    step(OP_DES, 15'h0000, 4'h0, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    step(OP_DES, 15'h0000, 4'h0, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    step(OP_PRD, 15'h0102, 4'h0, 32'h0000_0000, pat(2), FULL);
    flush();
    summarize();
  end
endmodule // testbench
